/* File: frg_motor_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Motor stage: integrates commanded frequency into rotor angle
module frg_motor_model (
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic [15:0] freq_in,     // Command, 0.01 Hz
    input  wire logic        running_in,  // Stage enabled
    output var  logic [31:0] angle_out    // Accumulated angle
);
    // Angle only advances while the stage is enabled
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            angle_out <= 32'h0;
        end else if (running_in) begin
            angle_out <= angle_out + {16'h0, freq_in};
        end
    end
endmodule
`default_nettype wire

/* File: frg_pkg.sv */
`default_nettype none
package frg_pkg;
    // Control clock and time figures
    localparam int     CLK_HZ       = 50_000_000;   // 50 MHz control clock
    localparam int     TENTH_MS     = 100;          // Coarse time step, 0.1 s
    localparam int     HUNDREDTH_MS = 10;           // Fine time step, 0.01 s
    localparam int     TINY_RAMP_MS = 30;           // Settings at or below this are too short
    localparam int     MIN_RAMP_MS  = 40;           // Ramp used instead of too-short settings
    localparam longint CYC_TENTH_D     = longint'(TENTH_MS) * CLK_HZ / 1000;
    localparam longint CYC_HUNDREDTH_D = longint'(HUNDREDTH_MS) * CLK_HZ / 1000;
    localparam longint CYC_TINY_D      = longint'(TINY_RAMP_MS) * CLK_HZ / 1000;
    localparam longint CYC_MIN_D       = (longint'(MIN_RAMP_MS) * CLK_HZ + 999) / 1000;

    // Register word indices; byte address is four times the index
    localparam int IDX_CTRL    = 0;   // Bit 0 run command
    localparam int IDX_SETF    = 1;   // Set frequency, 0.01 Hz
    localparam int IDX_ACC     = 2;   // accel_time
    localparam int IDX_DEC     = 3;   // decel_time
    localparam int IDX_ACC2    = 4;   // second_accel_time
    localparam int IDX_DEC2    = 5;   // second_decel_time
    localparam int IDX_REF     = 6;   // ramp_reference_freq
    localparam int IDX_TUNIT   = 7;   // time_unit_select
    localparam int IDX_SWF     = 8;   // ramp_switch_freq
    localparam int IDX_START   = 9;   // starting_freq
    localparam int IDX_HOLD    = 10;  // start_hold_time, 0.1 s
    localparam int IDX_BASE    = 11;  // base_freq
    localparam int IDX_SHAPE   = 12;  // ramp_shape_select
    localparam int IDX_MINF    = 13;  // minimum_freq
    localparam int IDX_JOG     = 14;  // jog_ramp_time
    localparam int IDX_RESTART = 15;  // restart_accel_time, always 0.1 s
    localparam int IDX_GAINA   = 16;  // gain_freq_a
    localparam int IDX_GAINB   = 17;  // gain_freq_b
    localparam int IDX_FSEL0   = 18;  // Input terminal function selects 18..24
    localparam int NUM_TERM    = 7;
    localparam int NUM_CFG     = 25;  // Writable words
    localparam int IDX_STATUS  = 25;  // Read-only status

    // Status and control fields
    localparam int CTRL_RUN_BIT    = 0;
    localparam int STAT_STATE_LSB  = 16;
    localparam int STAT_SECOND_BIT = 20;

    // Codes and limits
    localparam logic [15:0] CODE_OFF        = 16'h270F;  // 9999: function off / alias
    localparam logic [15:0] FUNC_SECOND_SET = 16'h0003;
    localparam logic [15:0] START_MAX       = 16'h1770;  // 60.00 Hz
    localparam logic [15:0] HOLD_MAX        = 16'h0064;  // 10.0 s
    localparam logic [15:0] START_FLOOR     = 16'h0001;  // 0.01 Hz
    localparam logic [15:0] SHAPE_S_A       = 16'h0001;

    // Values after reset
    localparam logic [15:0] CFG_RESET [0:NUM_CFG-1] = '{
        16'h0000, 16'h0000, 16'h0032, 16'h0032, 16'h0032, 16'h270F, 16'h1388,
        16'h0000, 16'h270F, 16'h0032, 16'h270F, 16'h1388, 16'h0000, 16'h0000,
        16'h0032, 16'h0000, 16'h1388, 16'h1388, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HOLD = 3'b010,
        ST_RAMP = 3'b100
    } frg_state_t;
endpackage
`default_nettype wire

/* File: frg_ramp_stepper.sv */
`timescale 1ns/100ps
`default_nettype none
module frg_ramp_stepper
    import frg_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        clear_in,   // Drop fractional progress
    input  wire logic        active_in,  // Ramp in progress
    input  wire logic [35:0] inc_in,     // Frequency span per ramp
    input  wire logic [63:0] thr_in,     // Cycles per ramp
    output var  logic        step_out    // One 0.01 Hz step due
);
    logic [63:0] acc_reg;  // Fractional progress
    logic [63:0] acc_sum;  // Progress after this cycle

    assign acc_sum = acc_reg + {28'h0000000, inc_in};

    // Error accumulator: span over cycles, exact over a whole ramp
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            acc_reg  <= 64'h0;
            step_out <= 1'b0;
        end else if (clear_in || !active_in) begin
            acc_reg  <= clear_in ? 64'h0 : acc_reg;
            step_out <= 1'b0;
        end else if (acc_sum >= thr_in) begin
            acc_reg  <= acc_sum - thr_in;
            step_out <= 1'b1;
        end else begin
            acc_reg  <= acc_sum;
            step_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: frg_ramp_top.sv */
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Rise 0 to reference takes accel time
// - Fall reference to 0 takes decel time
// - Time unit change rescales stored ramp times; here stored counts are read unchanged in the new unit
// - Second set on select input or threshold
// - Second decel code uses second accel
// - Select input routed by function code 3
// - Switch frequency off code: first set only
// - Switch frequency zero: second set always
// - Switch once output reaches threshold
// - Threshold above set: stays first set
// - Select input switches immediately
// - S-pattern A time refers to base
// - S-pattern A above base: quadratic time
// - Settings to 0.03 s give 0.04 s
// - Reference write leaves gain frequencies alone
// - Run and command reach start: jump
// - Command below start: no output
// - Starting frequency 0..60 Hz, resets 0.5
// - Start hold 0..10 s, off code
// - Start below minimum: run alone drives
// - Run drop during hold: decelerate now
// - Time unit defaults to 0.1 s
// - Zero starting frequency holds 0.01 Hz
module frg_ramp_top
    import frg_pkg::*;
#(
    parameter longint CYC_TENTH     = CYC_TENTH_D,      // Cycles per 0.1 s
    parameter longint CYC_HUNDREDTH = CYC_HUNDREDTH_D,  // Cycles per 0.01 s
    parameter longint CYC_TINY      = CYC_TINY_D,       // 0.03 s in cycles
    parameter longint CYC_MIN       = CYC_MIN_D         // 0.04 s in cycles
) (
    input  wire logic                ref_clk_in,
    input  wire logic                reset_n_in,
    input  wire logic                psel_in,
    input  wire logic                penable_in,
    input  wire logic                pwrite_in,
    input  wire logic [7:0]          paddr_in,
    input  wire logic [31:0]         pwdata_in,
    output var  logic [31:0]         prdata_out,
    output var  logic                pready_out,
    output var  logic                pslverr_out,
    input  wire logic [NUM_TERM-1:0] terminal_in,          // Input terminals
    output var  logic [15:0]         out_freq_out,         // Output frequency, 0.01 Hz
    output var  logic                running_out,          // Output active
    output var  logic                hold_active_out,      // Start hold in progress
    output var  logic                second_set_out        // Second ramp set in use
);
    // Register file and datapath state
    logic [15:0]      cfg_reg [0:NUM_CFG-1];  // Software settings
    logic [15:0]      out_freq_reg;           // Ramped output
    frg_state_t       state_reg;              // Start sequencer
    logic [31:0]      hold_cnt_reg;           // Hold cycles left

    // Decode helpers
    logic [5:0]       widx;                   // Word index from address
    logic             addr_ok;                // Mapped, aligned address
    logic             wr_fire;                // Write taken this edge
    logic [15:0]      wval;                   // Write value after clamping

    // Command conditioning
    logic             run_cmd;
    logic [15:0]      cmd_freq;               // Set frequency floored at minimum
    logic [15:0]      eff_start;              // Starting frequency actually used
    logic             start_ok;               // Run with command at/above start
    logic [15:0]      target;                 // Where the ramp heads

    // Ramp set selection
    logic             select_seen;
    logic             use_second;
    logic [15:0]      accel_sel;
    logic [15:0]      decel_sel;

    // Ramp rate
    logic             ramp_up;
    logic             ramp_dn;
    logic [15:0]      t_sel;                  // Ramp time setting in force
    logic [47:0]      cyc_unit;               // Cycles per time step
    logic [63:0]      t_raw;                  // Setting in cycles
    logic [63:0]      t_cyc;                  // After minimum ramp floor
    logic [35:0]      step_inc;
    logic [63:0]      step_thr;
    logic             step;

    assign widx    = paddr_in[7:2];
    assign addr_ok = (paddr_in[1:0] == 2'b00) && (widx <= 6'(IDX_STATUS));
    assign wr_fire = psel_in && penable_in && pready_out && pwrite_in && !pslverr_out;

    // Range limits applied on write
    always_comb begin
        wval = pwdata_in[15:0];
        if (widx == 6'(IDX_START) && wval > START_MAX) begin
            wval = START_MAX;
        end else if (widx == 6'(IDX_HOLD) && wval != CODE_OFF && wval > HOLD_MAX) begin
            wval = HOLD_MAX;
        end
    end

    // Settings storage; each word only changes on its own write
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < NUM_CFG; i++) begin
                cfg_reg[i] <= CFG_RESET[i];
            end
        end else if (wr_fire && widx < 6'(NUM_CFG)) begin
            // Reference write touches no gain word
            cfg_reg[widx[4:0]] <= wval;
        end
    end

    // Zero-wait APB: answer in the access cycle after every setup
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0;
        end else if (psel_in && !penable_in) begin
            pready_out  <= 1'b1;
            // Status is read-only; writing it is refused
            pslverr_out <= !addr_ok || (pwrite_in && widx == 6'(IDX_STATUS));
            if (!addr_ok || pwrite_in) begin
                prdata_out <= 32'h0;
            end else if (widx == 6'(IDX_STATUS)) begin
                prdata_out <= {11'h000, use_second, 1'b0, state_reg, out_freq_reg};
            end else begin
                prdata_out <= {16'h0000, cfg_reg[widx[4:0]]};
            end
        end else begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end
    end

    // Command conditioning
    always_comb begin
        run_cmd   = cfg_reg[IDX_CTRL][CTRL_RUN_BIT];
        // Start below minimum lets the run command alone drive
        cmd_freq  = (cfg_reg[IDX_SETF] < cfg_reg[IDX_MINF]) ?
                    cfg_reg[IDX_MINF] : cfg_reg[IDX_SETF];
        eff_start = (cfg_reg[IDX_START] == 16'h0000) ?
                    START_FLOOR : cfg_reg[IDX_START];
        start_ok  = run_cmd && (cmd_freq >= eff_start);
        target    = start_ok ? cmd_freq : 16'h0000;
    end

    frg_set_select u_set_select (
        .terminal_in    (terminal_in),
        .func_sel_in    ({cfg_reg[IDX_FSEL0+6], cfg_reg[IDX_FSEL0+5], cfg_reg[IDX_FSEL0+4],
                          cfg_reg[IDX_FSEL0+3], cfg_reg[IDX_FSEL0+2], cfg_reg[IDX_FSEL0+1],
                          cfg_reg[IDX_FSEL0]}),
        .switch_freq_in (cfg_reg[IDX_SWF]),
        .out_freq_in    (out_freq_reg),
        .acc1_in        (cfg_reg[IDX_ACC]),
        .dec1_in        (cfg_reg[IDX_DEC]),
        .acc2_in        (cfg_reg[IDX_ACC2]),
        .dec2_in        (cfg_reg[IDX_DEC2]),
        .select_in_out  (select_seen),
        .use_second_out (use_second),
        .accel_out      (accel_sel),
        .decel_out      (decel_sel)
    );

    // Ramp rate: span per ramp over cycles per ramp
    always_comb begin
        ramp_up  = (state_reg == ST_RAMP) && (out_freq_reg < target);
        ramp_dn  = (state_reg == ST_RAMP) && (out_freq_reg > target);
        t_sel    = ramp_up ? accel_sel : decel_sel;
        // Stored counts are read in the current unit; restart time is not rescaled
        cyc_unit = cfg_reg[IDX_TUNIT][0] ? 48'(CYC_HUNDREDTH) : 48'(CYC_TENTH);
        t_raw    = 64'(t_sel) * 64'(cyc_unit);
        // Very short settings are floored; the reference must then stay low
        t_cyc    = (t_raw <= 64'(CYC_TINY)) ? 64'(CYC_MIN) : t_raw;
        if (cfg_reg[IDX_SHAPE] == SHAPE_S_A && out_freq_reg >= cfg_reg[IDX_BASE]) begin
            // Above base: df/dt = 9 fb^2 / (8 T f), giving 4/9 T (f/fb)^2 + 5/9 T
            step_inc = 36'h9 * 36'(cfg_reg[IDX_BASE]) * 36'(cfg_reg[IDX_BASE]);
            step_thr = 64'h8 * t_cyc * 64'(out_freq_reg);
        end else if (cfg_reg[IDX_SHAPE] == SHAPE_S_A) begin
            step_inc = 36'(cfg_reg[IDX_BASE]);
            step_thr = t_cyc;
        end else begin
            step_inc = 36'(cfg_reg[IDX_REF]);
            step_thr = t_cyc;
        end
    end

    frg_ramp_stepper u_stepper (
        .clk_in     (ref_clk_in),
        .reset_n_in (reset_n_in),
        .clear_in   (!(ramp_up || ramp_dn)),
        .active_in  (ramp_up || ramp_dn),
        .inc_in     (step_inc),
        .thr_in     (step_thr),
        .step_out   (step)
    );

    // Start sequencer and output frequency
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg    <= ST_IDLE;
            out_freq_reg <= 16'h0000;
            hold_cnt_reg <= 32'h0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (start_ok) begin
                        out_freq_reg <= eff_start;
                        hold_cnt_reg <= 32'(64'(cfg_reg[IDX_HOLD]) * 64'(CYC_TENTH));
                        state_reg    <= (cfg_reg[IDX_HOLD] == CODE_OFF) ?
                                        ST_RAMP : ST_HOLD;
                    end else begin
                        out_freq_reg <= 16'h0000;
                    end
                end
                ST_HOLD: begin
                    if (!run_cmd) begin
                        state_reg <= ST_RAMP;
                    end else if (hold_cnt_reg == 32'h0) begin
                        state_reg <= ST_RAMP;
                    end else begin
                        hold_cnt_reg <= hold_cnt_reg - 32'h1;
                    end
                end
                ST_RAMP: begin
                    // Step already in flight is dropped once the target is met
                    if (step && ramp_up) begin
                        out_freq_reg <= out_freq_reg + 16'h0001;
                    end else if (step && ramp_dn) begin
                        out_freq_reg <= out_freq_reg - 16'h0001;
                    end else if (out_freq_reg == 16'h0000 && !start_ok) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Registered pin copies
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            out_freq_out    <= 16'h0000;
            running_out     <= 1'b0;
            hold_active_out <= 1'b0;
            second_set_out  <= 1'b0;
        end else begin
            out_freq_out    <= out_freq_reg;
            running_out     <= (state_reg != ST_IDLE);
            hold_active_out <= (state_reg == ST_HOLD);
            second_set_out  <= use_second;
        end
    end

    // Checks
    property p_no_start;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_reg == ST_IDLE && !start_ok) |=> (out_freq_reg == 16'h0000);
    endproperty
    a_no_start: assert property (p_no_start) else $error("output without start");

    property p_start_jump;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_reg == ST_IDLE && start_ok) |=> (out_freq_reg == $past(eff_start))
            ##1 (out_freq_out == $past(eff_start, 2));
    endproperty
    a_start_jump: assert property (p_start_jump) else $error("start not at start freq");

    property p_zero_start;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_reg == ST_IDLE && start_ok && cfg_reg[IDX_START] == 16'h0000)
            |=> (out_freq_reg == 16'h0001);
    endproperty
    a_zero_start: assert property (p_zero_start) else $error("zero start not 0.01 Hz");

    property p_hold_abort;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_reg == ST_HOLD && !run_cmd) |=> (state_reg == ST_RAMP) ##1 !hold_active_out;
    endproperty
    a_hold_abort: assert property (p_hold_abort) else $error("hold not ended by stop");

    property p_hold_off;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_reg == ST_IDLE && start_ok && cfg_reg[IDX_HOLD] == CODE_OFF)
            |=> (state_reg == ST_RAMP);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("hold taken while off");

    property p_select_wins;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        select_seen |-> use_second ##1 second_set_out;
    endproperty
    a_select_wins: assert property (p_select_wins) else $error("select input ignored");

    property p_switch_off;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (cfg_reg[IDX_SWF] == CODE_OFF && !select_seen) |-> !use_second;
    endproperty
    a_switch_off: assert property (p_switch_off) else $error("auto switch while off");

    property p_dec2_alias;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (use_second && cfg_reg[IDX_DEC2] == CODE_OFF) |-> (decel_sel == cfg_reg[IDX_ACC2]);
    endproperty
    a_dec2_alias: assert property (p_dec2_alias) else $error("decel alias missed");

    property p_tiny_floor;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (cfg_reg[IDX_SHAPE] != SHAPE_S_A && t_raw <= 64'(CYC_TINY)) |-> (step_thr == 64'(CYC_MIN));
    endproperty
    a_tiny_floor: assert property (p_tiny_floor) else $error("short ramp not floored");

    property p_one_step;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_reg == ST_RAMP && $past(state_reg) == ST_RAMP)
            |-> (out_freq_reg == $past(out_freq_reg) || out_freq_reg == $past(out_freq_reg) + 16'h0001
                 || out_freq_reg == $past(out_freq_reg) - 16'h0001);
    endproperty
    a_one_step: assert property (p_one_step) else $error("ramp jumped");

    property p_start_clamp;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (wr_fire && widx == 6'(IDX_START) && pwdata_in[15:0] > START_MAX)
            |=> (cfg_reg[IDX_START] == START_MAX);
    endproperty
    a_start_clamp: assert property (p_start_clamp) else $error("start freq not clamped");

    // Hold only ends early on a dropped run command
    property p_hold_stays;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_reg == ST_HOLD && run_cmd && hold_cnt_reg != 32'h0) |=> (state_reg == ST_HOLD);
    endproperty
    a_hold_stays: assert property (p_hold_stays) else $error("hold cut short");

    // Reaching a live threshold always selects the second set
    property p_swf_hit;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (cfg_reg[IDX_SWF] != CODE_OFF && out_freq_reg >= cfg_reg[IDX_SWF]) |-> use_second;
    endproperty
    a_swf_hit: assert property (p_swf_hit) else $error("threshold ignored");

    // Start below minimum: the run command alone leaves idle
    property p_min_run;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        (state_reg == ST_IDLE && run_cmd && cfg_reg[IDX_START] < cfg_reg[IDX_MINF])
            |=> (state_reg != ST_IDLE);
    endproperty
    a_min_run: assert property (p_min_run) else $error("min start missed");
endmodule
`default_nettype wire

/* File: frg_set_select.sv */
`timescale 1ns/100ps
`default_nettype none
module frg_set_select
    import frg_pkg::*;
(
    input  wire logic [NUM_TERM-1:0]       terminal_in,
    input  wire logic [NUM_TERM-1:0][15:0] func_sel_in,
    input  wire logic [15:0]               switch_freq_in,
    input  wire logic [15:0]               out_freq_in,
    input  wire logic [15:0]               acc1_in,
    input  wire logic [15:0]               dec1_in,
    input  wire logic [15:0]               acc2_in,
    input  wire logic [15:0]               dec2_in,
    output var  logic                      select_in_out,  // second_set_select seen
    output var  logic                      use_second_out,
    output var  logic [15:0]               accel_out,
    output var  logic [15:0]               decel_out
);
    // Terminal routing and set choice
    always_comb begin
        select_in_out = 1'b0;
        for (int i = 0; i < NUM_TERM; i++) begin
            if (func_sel_in[i] == FUNC_SECOND_SET && terminal_in[i]) begin
                select_in_out = 1'b1;
            end
        end
        // Off code never switches on threshold; zero switches from start; above set never reached
        use_second_out = select_in_out
            || (switch_freq_in != CODE_OFF && out_freq_in >= switch_freq_in);
        accel_out = use_second_out ? acc2_in : acc1_in;
        if (!use_second_out) begin
            decel_out = dec1_in;
        end else if (dec2_in == CODE_OFF) begin
            decel_out = acc2_in;
        end else begin
            decel_out = dec2_in;
        end
    end
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import frg_pkg::*;
    logic ref_clk_in = 0, reset_n_in = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, running, hold_on, second;
    logic [6:0]  terminal = 7'h01;  // Terminal 0 high, unassigned at first
    logic [15:0] freq;
    logic [31:0] angle;  // Motor stage angle
    int          fails = 0, checks_done = 0, n;
    // Small time base keeps the run short
    frg_ramp_top #(.CYC_TENTH(50), .CYC_HUNDREDTH(5), .CYC_TINY(15), .CYC_MIN(20))
    frg_ramp_top_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .terminal_in(terminal), .out_freq_out(freq), .running_out(running),
        .hold_active_out(hold_on), .second_set_out(second));
    frg_motor_model frg_motor_model_i (.clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .freq_in(freq), .running_in(running), .angle_out(angle));
    always #10 ref_clk_in = ~ref_clk_in;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk_in);
        penable <= 1;
        do @(posedge ref_clk_in); while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // Cycles until the output shows the target
    task ramp_time(input logic [15:0] target);
        n = 0;
        while (freq !== target && n < 3000) begin
            @(posedge ref_clk_in);
            n++;
        end
    endtask
    task give_verdict;
        $display("comparisons %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task reset_values;
        apb(0, 8'h24, 0); chk(rd, 32'h32);
        apb(0, 8'h28, 0); chk(rd, 32'h270F);
        apb(0, 8'h1C, 0); chk(rd, 32'h0);
        apb(0, 8'h68, 0); chk(err, 1'b1);
        apb(1, 8'h64, 5); chk(err, 1'b1);
        chk(second, 1'b0);
        chk(second, 1'b0);
    endtask
    task ref_and_gains;
        apb(1, 8'h18, 100); // Reference 1 Hz, well under 120 Hz
        apb(0, 8'h40, 0); chk(rd, 32'h1388);
        apb(0, 8'h44, 0); chk(rd, 32'h1388);
    endtask
    task start_and_rise;
        apb(1, 8'h08, 10);
        apb(1, 8'h04, 10);
        apb(1, 8'h00, 1);
        repeat (20) @(posedge ref_clk_in);
        chk(freq, 16'h0);
        chk(running, 1'b0);
        chk(angle, 32'h0);
        apb(1, 8'h04, 100);
        ramp_time(16'h32);
        chk(n < 8, 1'b1);
        ramp_time(16'h64);
        chk(n >= 240 && n <= 262, 1'b1);
    endtask
    task unit_and_fall;
        apb(1, 8'h1C, 1);
        apb(1, 8'h0C, 100);
        apb(1, 8'h00, 0);
        ramp_time(16'h0);
        chk(n >= 488 && n <= 515, 1'b1);
        chk(n < 1000, 1'b1);
        repeat (3) @(posedge ref_clk_in);
        chk(running, 1'b0);
    endtask
    task select_input;
        apb(1, 8'h48, 3);
        repeat (3) @(posedge ref_clk_in);
        chk(second, 1'b1);
    endtask
    // Threshold picks the set once the select terminal is low
    task switch_freq;
        terminal <= 7'h00;
        apb(1, 8'h20, 0);
        repeat (3) @(posedge ref_clk_in);
        chk(second, 1'b1);
        apb(1, 8'h20, 75);
        apb(1, 8'h00, 1);
        ramp_time(16'h32);
        chk(second, 1'b0);
        ramp_time(16'h64);
        chk(second, 1'b1);
        apb(1, 8'h20, 150);
        repeat (3) @(posedge ref_clk_in);
        chk(second, 1'b0);
        apb(1, 8'h00, 0);
        ramp_time(16'h0);
    endtask
    // S-pattern A: time refers to base, quadratic above it
    task sa_shape;
        apb(1, 8'h30, 1);
        apb(1, 8'h2C, 100);
        apb(1, 8'h18, 200); // Reference 2 Hz
        apb(1, 8'h08, 100);
        apb(1, 8'h20, 16'h270F);
        apb(1, 8'h04, 200);
        apb(1, 8'h00, 1);
        ramp_time(16'h32);
        ramp_time(16'h64);
        chk(n >= 240 && n <= 262, 1'b1);
        ramp_time(16'hC8);
        chk(n >= 650 && n <= 685, 1'b1);
        apb(1, 8'h30, 0);
        apb(1, 8'h00, 0);
        ramp_time(16'h0);
        chk(n >= 488 && n <= 515, 1'b1);
    endtask
    // Start hold, then a stop inside it decelerates on the second set
    task hold_and_abort;
        terminal <= 7'h01;
        apb(1, 8'h28, 2);
        apb(1, 8'h00, 1);
        repeat (5) @(posedge ref_clk_in);
        chk(hold_on, 1'b1);
        chk(freq, 16'h32);
        apb(1, 8'h00, 0);
        repeat (3) @(posedge ref_clk_in);
        chk(hold_on, 1'b0);
        chk(running, 1'b1);
        ramp_time(16'h0);
        chk(n >= 58 && n <= 70, 1'b1);
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_in);
        reset_n_in <= 1;
        reset_values();
        ref_and_gains();
        start_and_rise();
        unit_and_fall();
        select_input();
        switch_freq();
        sa_shape();
        hold_and_abort();
        give_verdict();
    end
    initial begin
        #400000;
        fails++;
        give_verdict();
    end
endmodule
`default_nettype wire
